// [inc/tone_consts.vh]
`ifndef TONE_CONSTS_VH
`define TONE_CONSTS_VH
// register byte addresses
`define ADDR_TX_DATA      5'h00
`define ADDR_CONTROL      5'h04
`define ADDR_STATUS       5'h08
`define ADDR_CP_INPUT     5'h0c
// first control register fields
`define CRA_TONE_OUT      0
`define CRA_CP_SELECT     1
`define CRA_IRQ_EN        2
`define CRA_REG_SELECT    3
// second control register fields
`define CRB_BURST_EN      0
`define CRB_RX_EN         1
`define CRB_SINGLE        2
`define CRB_COL_ROW       3
// status fields
`define ST_TX_READY       1
// reset values
`define CRA_RESET         4'h0
`define CRB_RESET         4'h0
// reference clock, in Hz, and the system clock
`define REF_CLK_HZ        3579545
`define SYS_CLK_HZ        20000000
// reference clock enable as a phase accumulator: step = ref/sys * 2^24
`define REF_STEP          24'h2dd1ab
// burst length in reference cycles: 51 ms of 3.579545 MHz
`define BURST_MS          51
`define BURST_REF_CYCLES  ((`REF_CLK_HZ / 1000) * `BURST_MS)
`endif

// [logic/tone_burst_generator.v]
`include "tone_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module tone_burst_generator
(
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [4:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [4:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        cp_tone_in,
	input  wire        cp_in_band,
	output reg  [3:0]  row_sample_q,
	output reg  [3:0]  col_sample_q,
	output wire        tone_out_oe,
	output reg         event_or_tone_pin_o,
	output reg         event_or_tone_pin_oe,
	output wire        rx_detect_enable,
	output wire        cp_detect_enable
);
	localparam PH_IDLE  = 2'h0;
	localparam PH_BURST = 2'h1;
	localparam PH_PAUSE = 2'h2;
	localparam [31:0] BURST_LEN = `BURST_REF_CYCLES;

	reg  [3:0]  first_control_register_q;
	reg  [3:0]  second_control_register_q;
	reg         second_register_select_q;
	reg  [3:0]  tx_code_q;
	reg         tx_valid_q;
	reg         tx_ready_q;
	reg  [1:0]  phase_q;
	reg  [19:0] burst_cnt_q;
	reg  [23:0] ref_acc_q;
	reg         ref_tick_q;
	reg         aw_hold_q;
	reg         w_hold_q;
	reg  [4:0]  aw_addr_q;
	reg  [3:0]  w_data_q;
	reg         w_lane_q;
	reg  [1:0]  cp_sync_q;
	reg  [1:0]  band_sync_q;
	wire [3:0]  row_s;
	wire [3:0]  col_s;
	wire [24:0] acc_sum;
	wire        tone_output_enable;
	wire        call_progress_mode;
	wire        irq_en;
	wire        burst_en;
	wire        single_tone;
	wire        single_col;
	wire        do_write;
	wire        tone_active;
	wire        row_run;
	wire        col_run;
	wire [19:0] phase_len;

	assign tone_output_enable = first_control_register_q[`CRA_TONE_OUT];
	assign call_progress_mode = first_control_register_q[`CRA_CP_SELECT];
	assign irq_en             = first_control_register_q[`CRA_IRQ_EN];
	assign burst_en           = second_control_register_q[`CRB_BURST_EN];
	assign single_tone        = second_control_register_q[`CRB_SINGLE];
	assign single_col         = second_control_register_q[`CRB_COL_ROW];

	// reference-rate enable, fractional so the tones keep crystal accuracy
	assign acc_sum = {1'b0, ref_acc_q} + {1'b0, `REF_STEP};
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ref_acc_q  <= 24'h000000;
			ref_tick_q <= 1'b0;
		end
		else
		begin
			ref_acc_q  <= acc_sum[23:0];
			ref_tick_q <= acc_sum[24];
		end
	end

	// write channel: address and data taken in either order
	assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
	assign do_write      = aw_hold_q && w_hold_q;

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_q    <= 1'b0;
			w_hold_q     <= 1'b0;
			aw_addr_q    <= 5'h00;
			w_data_q     <= 4'h0;
			w_lane_q     <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_hold_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_hold_q <= 1'b1;
				w_data_q <= s_axi_wdata[3:0];
				w_lane_q <= s_axi_wstrb[0];
			end
			if (do_write)
			begin
				aw_hold_q    <= 1'b0;
				w_hold_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_addr_q == `ADDR_TX_DATA || aw_addr_q == `ADDR_CONTROL)
					? 2'h0 : 2'h2;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// control registers share one address, steered by the select bit
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			first_control_register_q  <= `CRA_RESET;
			second_control_register_q <= `CRB_RESET;
			second_register_select_q  <= 1'b0;
		end
		else if (do_write && w_lane_q && aw_addr_q == `ADDR_CONTROL)
		begin
			if (second_register_select_q)
			begin
				second_control_register_q <= w_data_q;
				second_register_select_q  <= 1'b0;
			end
			else
			begin
				first_control_register_q <= w_data_q;
				second_register_select_q <= w_data_q[`CRA_REG_SELECT];
			end
		end
	end

	// burst timer; length doubles in call progress mode
	assign phase_len = call_progress_mode ? {BURST_LEN[18:0], 1'b0}
		: BURST_LEN[19:0];

	always @(posedge aclk)
	begin
		if (!aresetn || !tone_output_enable)
		begin
			tx_code_q   <= 4'h0;
			tx_valid_q  <= 1'b0;
			tx_ready_q  <= 1'b0;
			phase_q     <= PH_IDLE;
			burst_cnt_q <= 20'h00000;
		end
		else
		begin
			if (do_write && w_lane_q && aw_addr_q == `ADDR_TX_DATA)
			begin
				tx_code_q   <= w_data_q;
				tx_valid_q  <= 1'b1;
				tx_ready_q  <= 1'b0;
				phase_q     <= burst_en ? PH_BURST : PH_IDLE;
				burst_cnt_q <= 20'h00000;
			end
			else if (ref_tick_q)
			begin
				case (phase_q)
					PH_BURST:
					begin
						if (burst_cnt_q == phase_len - 20'h00001)
						begin
							burst_cnt_q <= 20'h00000;
							phase_q     <= PH_PAUSE;
						end
						else
							burst_cnt_q <= burst_cnt_q + 20'h00001;
					end
					PH_PAUSE:
					begin
						if (burst_cnt_q == phase_len - 20'h00001)
						begin
							burst_cnt_q <= 20'h00000;
							phase_q     <= PH_IDLE;
							tx_valid_q  <= 1'b0;
							tx_ready_q  <= 1'b1;
						end
						else
							burst_cnt_q <= burst_cnt_q + 20'h00001;
					end
					default:
						phase_q <= PH_IDLE;
				endcase
			end
		end
	end

	// continuous tone without burst mode, timed burst otherwise
	assign tone_active = tx_valid_q && (burst_en ? (phase_q == PH_BURST) : 1'b1);
	// single tone picks one group by the column/row bit
	assign row_run = tone_active && !(single_tone && single_col);
	assign col_run = tone_active && !(single_tone && !single_col);
	assign tone_out_oe = tone_output_enable;

	// two identical chains, row and column
	tone_chain row_chain
	(
		.aclk      (aclk),
		.aresetn   (aresetn),
		.ref_tick  (ref_tick_q),
		.run       (row_run),
		.sel       (tx_code_q[3:2]),
		.row_group (1'b1),
		.sample_q  (row_s)
	);

	tone_chain col_chain
	(
		.aclk      (aclk),
		.aresetn   (aresetn),
		.ref_tick  (ref_tick_q),
		.run       (col_run),
		.sel       (tx_code_q[1:0]),
		.row_group (1'b0),
		.sample_q  (col_s)
	);

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			row_sample_q <= 4'h8;
			col_sample_q <= 4'h8;
		end
		else
		begin
			row_sample_q <= row_s;
			col_sample_q <= col_s;
		end
	end

	// comparator output and band flag come from the analog side
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cp_sync_q   <= 2'h0;
			band_sync_q <= 2'h0;
		end
		else
		begin
			cp_sync_q   <= {cp_sync_q[0], cp_tone_in};
			band_sync_q <= {band_sync_q[0], cp_in_band};
		end
	end

	assign rx_detect_enable = !call_progress_mode;
	assign cp_detect_enable = call_progress_mode;

	// open drain: driven only low, or released for the pull-up
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			event_or_tone_pin_o  <= 1'b0;
			event_or_tone_pin_oe <= 1'b0;
		end
		else if (call_progress_mode)
		begin
			event_or_tone_pin_o <= 1'b0;
			// low out of band, else follows the squared tone (low while it is low, released while it is high)
			event_or_tone_pin_oe <= irq_en && !(band_sync_q[1] && cp_sync_q[1]);
		end
		else
		begin
			event_or_tone_pin_o  <= 1'b0;
			event_or_tone_pin_oe <= irq_en && burst_en && tx_ready_q;
		end
	end

	// read channel
	assign s_axi_arready = !s_axi_rvalid;
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= 2'h0;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= 2'h0;
			case (s_axi_araddr)
				`ADDR_CONTROL: s_axi_rdata <= {27'h0000000, second_register_select_q,
					first_control_register_q};
				`ADDR_STATUS:  s_axi_rdata <= {26'h0000000, phase_q, 2'h0, tx_ready_q, 1'b0};
				`ADDR_CP_INPUT: s_axi_rdata <= {28'h0000000, second_control_register_q};
				default:
				begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= 2'h2;
				end
			endcase
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
endmodule
`default_nettype wire

// [logic/tone_chain.v]
`timescale 1ns/100ps
`default_nettype none
module tone_chain
(
	input  wire       aclk,
	input  wire       aresetn,
	input  wire       ref_tick,
	input  wire       run,
	input  wire [1:0] sel,
	input  wire       row_group,
	output reg  [3:0] sample_q
);
	reg  [10:0] div_q;
	reg  [4:0]  seg_q;
	reg  [10:0] term;
	reg  [3:0]  sine;
	reg  [1:0]  sel_q;

	always @*
	begin
		// divide ratios are ref / (32 * f) minus one
		case ({row_group, sel})
			3'h4: term = 11'h0a0;
			3'h5: term = 11'h091;
			3'h6: term = 11'h083;
			3'h7: term = 11'h075;
			3'h0: term = 11'h05b;
			3'h1: term = 11'h053;
			3'h2: term = 11'h04b;
			3'h3: term = 11'h043;
			default: term = 11'h0a0;
		endcase
	end

	always @*
	begin
		case (seg_q[3:0])
			4'h0: sine = 4'h0;
			4'h1: sine = 4'h2;
			4'h2: sine = 4'h3;
			4'h3: sine = 4'h5;
			4'h4: sine = 4'h6;
			4'h5: sine = 4'h6;
			4'h6: sine = 4'h7;
			4'h7: sine = 4'h7;
			4'h8: sine = 4'h7;
			4'h9: sine = 4'h7;
			4'ha: sine = 4'h6;
			4'hb: sine = 4'h6;
			4'hc: sine = 4'h5;
			4'hd: sine = 4'h3;
			4'he: sine = 4'h2;
			default: sine = 4'h0;
		endcase
	end

	always @(posedge aclk)
	begin
		if (!aresetn || !run)
		begin
			div_q    <= 11'h000;
			seg_q    <= 5'h00;
			sel_q    <= 2'h0;
			sample_q <= 4'h8;
		end
		else
		begin
			sel_q <= sel;
			// retune restarts the segment, so no runt segment is left behind
			if (sel != sel_q)
				div_q <= 11'h000;
			else if (ref_tick)
			begin
				if (div_q >= term)
				begin
					div_q <= 11'h000;
					seg_q <= seg_q + 5'h01;
				end
				else
					div_q <= div_q + 11'h001;
				sample_q <= seg_q[4] ? (4'h8 - sine) : (4'h8 + sine);
			end
		end
	end
endmodule
`default_nettype wire

// [test/dtmf_tone_burst_generator_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module dtmf_tone_burst_generator_tb;
	logic		aclk, aresetn, band, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic		s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic		s_axi_rvalid, s_axi_rready, cp_tone_in, cp_in_band, tone_out_oe;
	logic		event_or_tone_pin_o, event_or_tone_pin_oe, rx_detect_enable, cp_detect_enable;
	logic [4:0]	s_axi_awaddr, s_axi_araddr;
	logic [31:0]	s_axi_wdata, s_axi_rdata, d, second_control_register, code;
	logic [3:0]	s_axi_wstrb, row_sample_q, col_sample_q;
	logic [1:0]	s_axi_bresp, s_axi_rresp, r, b;
	int		n_fail, compares, cyc, seed, pr, pc, k;
	tone_burst_generator i_dut
	(
		.aclk                 (aclk),
		.aresetn              (aresetn),
		.s_axi_awaddr         (s_axi_awaddr),
		.s_axi_awvalid        (s_axi_awvalid),
		.s_axi_awready        (s_axi_awready),
		.s_axi_wdata          (s_axi_wdata),
		.s_axi_wstrb          (s_axi_wstrb),
		.s_axi_wvalid         (s_axi_wvalid),
		.s_axi_wready         (s_axi_wready),
		.s_axi_bresp          (s_axi_bresp),
		.s_axi_bvalid         (s_axi_bvalid),
		.s_axi_bready         (s_axi_bready),
		.s_axi_araddr         (s_axi_araddr),
		.s_axi_arvalid        (s_axi_arvalid),
		.s_axi_arready        (s_axi_arready),
		.s_axi_rdata          (s_axi_rdata),
		.s_axi_rresp          (s_axi_rresp),
		.s_axi_rvalid         (s_axi_rvalid),
		.s_axi_rready         (s_axi_rready),
		.cp_tone_in           (cp_tone_in),
		.cp_in_band           (cp_in_band),
		.row_sample_q         (row_sample_q),
		.col_sample_q         (col_sample_q),
		.tone_out_oe          (tone_out_oe),
		.event_or_tone_pin_o  (event_or_tone_pin_o),
		.event_or_tone_pin_oe (event_or_tone_pin_oe),
		.rx_detect_enable     (rx_detect_enable),
		.cp_detect_enable     (cp_detect_enable)
	);
	tel_line i_line (.aclk, .band, .cp_tone_in, .cp_in_band);
	initial
	begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	task check(input logic [31:0] g, e);
		compares++;
		if (g !== e)
		begin
			n_fail++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
		end
	endtask
	task final_report;
		$display("compares %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task wr(input logic [4:0] a, input logic [31:0] v);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		fork
			begin do @(posedge aclk); while (!s_axi_awready); s_axi_awvalid <= 1'b0; end
			begin do @(posedge aclk); while (!s_axi_wready); s_axi_wvalid <= 1'b0; end
		join
		do @(posedge aclk); while (!s_axi_bvalid);
		b = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task rd(input logic [4:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// one tone period, from one upward midscale crossing to the next
	task automatic per(input bit c, output int p);
		int		n, k, t0;
		logic [3:0]	v, o;
		n = 0; k = 0; t0 = 0; o = 4'hf;
		while (k < 2)
		begin
			@(posedge aclk);
			n++;
			v = c ? col_sample_q : row_sample_q;
			if (o < 8 && v >= 8)
			begin
				k++;
				if (k == 1) t0 = n;
			end
			o = v;
		end
		p = n - t0;
	endtask
	// tolerance covers integer divide ratios, yet still tells neighbours apart
	function automatic bit okf(int p, int idx);
		int	fs[8] = '{697, 770, 852, 941, 1209, 1336, 1477, 1633};
		int	e;
		e = fs[idx] * p - 20000000;
		okf = (e < 240000 && e > -240000);
	endfunction
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 100000)
		begin
			n_fail++;
			final_report;
		end
	end
	initial
	begin
		seed = 97; n_fail = 0; compares = 0; band = 1'b0; aresetn = 1'b0;
		s_axi_awaddr = 5'h00; s_axi_araddr = 5'h00; s_axi_wdata = 32'h0; s_axi_wstrb = 4'hf;
		s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0; s_axi_rready = 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rd(5'h04);
		check(d, 32'h0);
		rd(5'h08);
		check(d, 32'h0);
		rd(5'h10);
		check(r, 32'h2);
		wr(5'h08, 32'hf);
		check(b, 32'h2);
		$display("reset test done");
		second_control_register = $random(seed) & 32'h2;
		wr(5'h04, 32'h8);
		wr(5'h04, second_control_register);
		check(b, 32'h0);
		rd(5'h0c);
		check(d, second_control_register);
		wr(5'h04, 32'h1);
		check(tone_out_oe, 32'h1);
		code = $random(seed) & 32'hf;
		wr(5'h00, code);
		wr(5'h00, code ^ 32'hf);
		fork
			per(1'b0, pr);
			per(1'b1, pc);
		join
		check(okf(pr, code[3:2] ^ 2'h3), 32'h1);
		check(okf(pc, 4 + (code[1:0] ^ 2'h3)), 32'h1);
		$display("tone test done");
		wr(5'h04, 32'h9);
		wr(5'h04, 32'hc);
		k = 0;
		repeat (1200)
		begin
			@(posedge aclk);
			if (col_sample_q != 4'h8)
				k = 1;
		end
		check(row_sample_q, 32'h8);
		check(k, 32'h1);
		$display("single tone test done");
		wr(5'h04, 32'h9);
		wr(5'h04, second_control_register | 32'h1);
		wr(5'h00, 32'h5);
		repeat (200) @(posedge aclk);
		rd(5'h08);
		check(d[1], 32'h0);
		check(d[5:4], 32'h1);
		$display("burst test done");
		wr(5'h04, 32'h7);
		check(cp_detect_enable, 32'h1);
		check(rx_detect_enable, 32'h0);
		band <= 1'b1;
		repeat (4)
		begin
			@(cp_tone_in);
			repeat (10) @(posedge aclk);
			check(event_or_tone_pin_oe, !cp_tone_in);
			check(event_or_tone_pin_o, 32'h0);
		end
		band <= 1'b0;
		repeat (10) @(posedge aclk);
		check(event_or_tone_pin_oe, 32'h1);
		wr(5'h04, 32'h3);
		repeat (4) @(posedge aclk);
		check(event_or_tone_pin_oe, 32'h0);
		$display("call progress test done");
		wr(5'h04, 32'h0);
		check(tone_out_oe, 32'h0);
		rd(5'h08);
		check(d[1], 32'h0);
		check(d[5:4], 32'h0);
		repeat (4) @(posedge aclk);
		check(row_sample_q, 32'h8);
		$display("power down test done");
		final_report;
	end
endmodule
`default_nettype wire

// [test/tel_line.sv]
`timescale 1ns/100ps
`default_nettype none
module tel_line #(parameter int HALF = 150)
(
	input  wire logic	aclk,
	input  wire logic	band,
	output var  logic	cp_tone_in,
	output var  logic	cp_in_band
);
	int	n = 0;
	initial cp_tone_in = 1'b0;
	// line comparator never rests, so the square runs free
	always @(posedge aclk)
	begin
		n <= (n == HALF - 1) ? 0 : n + 1;
		if (n == HALF - 1)
			cp_tone_in <= ~cp_tone_in;
		cp_in_band <= band;
	end
endmodule
`default_nettype wire

// [test/tone_burst_generator_checker.sv]
`timescale 1ns/100ps
`default_nettype none
module tone_burst_generator_checker
(
	input  wire logic	aclk,
	input  wire logic	aresetn,
	input  wire logic	s_axi_awvalid,
	input  wire logic	s_axi_awready,
	input  wire logic	s_axi_bvalid,
	input  wire logic	s_axi_bready,
	input  wire logic	s_axi_arvalid,
	input  wire logic	s_axi_arready,
	input  wire logic	s_axi_rvalid,
	input  wire logic	s_axi_rready,
	input  wire logic [3:0]	row_sample_q,
	input  wire logic [3:0]	col_sample_q,
	input  wire logic	tone_out_oe,
	input  wire logic	event_or_tone_pin_oe,
	input  wire logic	rx_detect_enable,
	input  wire logic	cp_detect_enable
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_wr_ans; s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid; endproperty
	a_wr_ans: assert property (p_wr_ans) else $error("no write response");
	property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("no read response");
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
	property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
	a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
	property p_aw_block; s_axi_bvalid |-> !s_axi_awready; endproperty
	a_aw_block: assert property (p_aw_block) else $error("write taken early");
	property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_ar_block: assert property (p_ar_block) else $error("read taken early");
	property p_cp_excl; cp_detect_enable != rx_detect_enable; endproperty
	a_cp_excl: assert property (p_cp_excl) else $error("detect modes overlap");
	property p_off_mid;
		!tone_out_oe [*4] |-> row_sample_q == 4'h8 && col_sample_q == 4'h8;
	endproperty
	a_off_mid: assert property (p_off_mid) else $error("tone not silent");
	// shortest segment spans far more than 8 cycles
	property p_seg; $changed(row_sample_q) && tone_out_oe |=> $stable(row_sample_q) [*8];
	endproperty
	a_seg: assert property (p_seg) else $error("segment too short");
	c_wr: cover property (s_axi_bvalid && s_axi_bready);
	c_cp: cover property (cp_detect_enable && event_or_tone_pin_oe);
	c_col: cover property ($changed(col_sample_q));
endmodule
bind tone_burst_generator tone_burst_generator_checker i_chk
(
	.aclk                 (aclk),
	.aresetn              (aresetn),
	.s_axi_awvalid        (s_axi_awvalid),
	.s_axi_awready        (s_axi_awready),
	.s_axi_bvalid         (s_axi_bvalid),
	.s_axi_bready         (s_axi_bready),
	.s_axi_arvalid        (s_axi_arvalid),
	.s_axi_arready        (s_axi_arready),
	.s_axi_rvalid         (s_axi_rvalid),
	.s_axi_rready         (s_axi_rready),
	.row_sample_q         (row_sample_q),
	.col_sample_q         (col_sample_q),
	.tone_out_oe          (tone_out_oe),
	.event_or_tone_pin_oe (event_or_tone_pin_oe),
	.rx_detect_enable     (rx_detect_enable),
	.cp_detect_enable     (cp_detect_enable)
);
`default_nettype wire
